// ==== ctm_core_timing.sv ====
// Purpose: instruction sequencer that paces execution in system clocks
// Assumes: opcode, operands and pointers come from logic on ref_clk
// Notes: debug pins are asynchronous and pass a three stage synchroniser
`timescale 1ns/1ps

module ctm_core_timing (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// opcode issue
	input wire logic op_valid,
	input wire logic [ctm_pkg::OPW-1:0] op_code,
	input wire logic [ctm_pkg::OPW-1:0] op_arg,
	input wire logic cond_true,
	output logic op_ready,
	output logic instr_done,
	output logic [1:0] instr_len,
	output logic [ctm_pkg::CYW-1:0] instr_cycles,
	// accumulator and auxiliary operands
	input wire logic [ctm_pkg::OPW-1:0] acc_in,
	input wire logic [ctm_pkg::OPW-1:0] aux_in,
	output logic [ctm_pkg::OPW-1:0] acc_out,
	output logic [ctm_pkg::OPW-1:0] aux_out,
	output logic ov_flag,
	// memory steering
	input wire logic [1:0] program_store_control,
	output logic flash_wr,
	output logic flash_erase,
	output logic flash_rd,
	output logic xram_rd,
	output logic xram_wr,
	output logic sfr_sel,
	output logic ram_sel,
	output logic sixteen_bit_data_pointer_inc,
	// debug
	input wire logic dbg_halt_pin,
	input wire logic dbg_run_pin,
	input wire logic dbg_step_pin,
	input wire logic [ctm_pkg::ADW-1:0] pc_in,
	input wire logic bkpt_en,
	input wire logic [ctm_pkg::ADW-1:0] bkpt_addr,
	input wire logic watch_en,
	input wire logic [ctm_pkg::ADW-1:0] watch_addr,
	input wire logic [ctm_pkg::ADW-1:0] xdata_addr,
	output logic halted
);
	import ctm_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	ctm_dec_if dec_if ();
	ctm_state_t state_r;
	ctm_kind_t kind_r;
	ctm_kind_t kind_now;
	logic [3:0] cnt_r;
	logic [3:0] run_cyc;
	logic op_ready_r;
	logic done_r;
	logic [1:0] len_r;
	logic [3:0] cyc_r;
	logic [7:0] acc_r;
	logic [7:0] aux_r;
	logic [7:0] acc_pend_r;
	logic [7:0] aux_pend_r;
	logic ov_r;
	logic ov_pend_r;
	logic [15:0] prod;
	logic take;
	logic fin;
	logic fwr_r;
	logic fer_r;
	logic frd_r;
	logic xrd_r;
	logic xwr_r;
	logic sfr_r;
	logic ram_r;
	logic dpi_r;
	logic halted_r;
	logic halt_pend_r;
	logic step_r;
	logic set_halt;
	logic [2:0] sy1_r;
	logic [2:0] sy2_r;
	logic [2:0] sy3_r;
	logic [2:0] stab_r;
	logic [2:0] stab_d_r;
	logic [2:0] evt;

	// ------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------
	assign dec_if.opcode = op_code;

	ctm_op_decode u_dec (
		.dbus(dec_if.dec)
	);

	always_comb begin
		run_cyc = dec_if.cyc;
		if (dec_if.kind == K_BRANCH && !cond_true) begin
			run_cyc = dec_if.cyc - CYC_ONE;
		end
		if (run_cyc > CYC_MAX) begin
			run_cyc = CYC_MAX;
		end
	end

	assign take = op_valid && op_ready_r;
	assign kind_now = (state_r == ST_EXEC) ? kind_r : dec_if.kind;
	// last clock of the running instruction
	assign fin = (take && run_cyc == CYC_ONE) || (state_r == ST_EXEC && cnt_r == CYC_ONE);
	// operands widened first so the product keeps its high byte
	assign prod = {8'h00, acc_in} * {8'h00, aux_in};

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// clock-by-clock countdown
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r <= ST_READY;
			cnt_r <= CNT_RST;
			op_ready_r <= 1'b1;
			halted_r <= 1'b0;
			kind_r <= K_PLAIN;
		end else begin
			case (state_r)
				ST_READY: begin
					if (take) begin
						cnt_r <= run_cyc - CYC_ONE;
						kind_r <= dec_if.kind;
						if (run_cyc == CYC_ONE) begin
							if (halt_pend_r || set_halt) begin
								state_r <= ST_HALT;
								op_ready_r <= 1'b0;
								halted_r <= 1'b1;
							end
						end else begin
							state_r <= ST_EXEC;
							op_ready_r <= 1'b0;
						end
					end else if (halt_pend_r) begin
						state_r <= ST_HALT;
						op_ready_r <= 1'b0;
						halted_r <= 1'b1;
					end
				end
				ST_EXEC: begin
					cnt_r <= cnt_r - CYC_ONE;
					if (cnt_r == CYC_ONE) begin
						if (halt_pend_r) begin
							state_r <= ST_HALT;
							halted_r <= 1'b1;
						end else begin
							state_r <= ST_READY;
							op_ready_r <= 1'b1;
						end
					end
				end
				ST_HALT: begin
					if (evt[1] || evt[2]) begin
						state_r <= ST_READY;
						op_ready_r <= 1'b1;
						halted_r <= 1'b0;
					end
				end
				default: begin
					state_r <= ST_READY;
					op_ready_r <= 1'b1;
				end
			endcase
		end
	end

	// completion pulse and issued timing
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			done_r <= 1'b0;
			len_r <= 2'd0;
			cyc_r <= CNT_RST;
		end else begin
			done_r <= fin;
			if (take) begin
				len_r <= dec_if.len;
				cyc_r <= run_cyc;
			end
		end
	end

	// ------------------------------------------------------------
	// multiply and divide
	// ------------------------------------------------------------
	// result held until the last clock
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc_pend_r <= BYTE_RST;
			aux_pend_r <= BYTE_RST;
			ov_pend_r <= 1'b0;
			acc_r <= BYTE_RST;
			aux_r <= BYTE_RST;
			ov_r <= 1'b0;
		end else begin
			if (take && dec_if.kind == K_MUL) begin
				acc_pend_r <= prod[7:0];
				aux_pend_r <= prod[15:8];
				ov_pend_r <= (prod[15:8] != BYTE_RST);
			end else if (take && dec_if.kind == K_DIV) begin
				if (aux_in == BYTE_RST) begin
					acc_pend_r <= acc_in;
					aux_pend_r <= aux_in;
					ov_pend_r <= 1'b1;
				end else begin
					acc_pend_r <= acc_in / aux_in;
					aux_pend_r <= acc_in % aux_in;
					ov_pend_r <= 1'b0;
				end
			end
			if (fin && (kind_now == K_MUL || kind_now == K_DIV)) begin
				acc_r <= acc_pend_r;
				aux_r <= aux_pend_r;
				ov_r <= ov_pend_r;
			end
		end
	end

	// ------------------------------------------------------------
	// memory steering
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fwr_r <= 1'b0;
			fer_r <= 1'b0;
			frd_r <= 1'b0;
			xrd_r <= 1'b0;
			xwr_r <= 1'b0;
			dpi_r <= 1'b0;
		end else begin
			fwr_r <= fin && kind_now == K_XWR && program_store_control[PSC_WREN];
			fer_r <= fin && kind_now == K_XWR && program_store_control[PSC_WREN]
				&& program_store_control[PSC_ERASE];
			xwr_r <= fin && kind_now == K_XWR && !program_store_control[PSC_WREN];
			xrd_r <= fin && kind_now == K_XRD;
			frd_r <= fin && kind_now == K_CODE;
			dpi_r <= fin && kind_now == K_DPINC;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sfr_r <= 1'b0;
			ram_r <= 1'b0;
		end else if (take) begin
			sfr_r <= dec_if.direct && (op_arg >= SFR_BASE);
			ram_r <= dec_if.indir || (dec_if.direct && (op_arg < SFR_BASE));
		end
	end

	// ------------------------------------------------------------
	// debug control
	// ------------------------------------------------------------
	// three stage synchroniser per pin: halt, run, step
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					sy1_r[gi] <= 1'b0;
					sy2_r[gi] <= 1'b0;
					sy3_r[gi] <= 1'b0;
					stab_r[gi] <= 1'b0;
					stab_d_r[gi] <= 1'b0;
				end else begin
					sy1_r[gi] <= (gi == 0) ? dbg_halt_pin : (gi == 1) ? dbg_run_pin : dbg_step_pin;
					sy2_r[gi] <= sy1_r[gi];
					sy3_r[gi] <= sy2_r[gi];
					stab_d_r[gi] <= stab_r[gi];
					// level accepted once stages two and three agree
					if (sy2_r[gi] == sy3_r[gi]) begin
						stab_r[gi] <= sy3_r[gi];
					end
				end
			end
			assign evt[gi] = stab_r[gi] && !stab_d_r[gi];
		end
	endgenerate

	// halt sources: pin, breakpoint, watchpoint, step
	assign set_halt = evt[0] || (take && step_r)
		|| (take && bkpt_en && pc_in == bkpt_addr)
		|| (take && watch_en && xdata_addr == watch_addr
			&& (dec_if.kind == K_XRD || dec_if.kind == K_XWR));

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			halt_pend_r <= 1'b0;
			step_r <= 1'b0;
		end else begin
			// a new halt request wins over the clear
			if (set_halt) begin
				halt_pend_r <= 1'b1;
			end else if (state_r == ST_HALT) begin
				halt_pend_r <= 1'b0;
			end
			if (state_r == ST_HALT && evt[2]) begin
				step_r <= 1'b1;
			end else if (take) begin
				step_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign op_ready = op_ready_r;
	assign instr_done = done_r;
	assign instr_len = len_r;
	assign instr_cycles = cyc_r;
	assign acc_out = acc_r;
	assign aux_out = aux_r;
	assign ov_flag = ov_r;
	assign flash_wr = fwr_r;
	assign flash_erase = fer_r;
	assign flash_rd = frd_r;
	assign xram_rd = xrd_r;
	assign xram_wr = xwr_r;
	assign sfr_sel = sfr_r;
	assign ram_sel = ram_r;
	assign sixteen_bit_data_pointer_inc = dpi_r;
	assign halted = halted_r;

endmodule // ctm_core_timing

// ==== ctm_pkg.sv ====
// Purpose: shared constants and types of the instruction timing core
// Assumes: one system clock, every timing figure counted in clocks
// Notes: opcode values follow the standard 8-bit accumulator set
package ctm_pkg;

	// ------------------------------------------------------------
	// widths and limits
	// ------------------------------------------------------------
	localparam int OPW = 8;
	localparam int ADW = 16;
	localparam int CYW = 4;
	localparam logic [3:0] CYC_MAX = 4'h8; // longest instruction
	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_MUL = 4'h4;
	localparam logic [3:0] CYC_DIV = 4'h8;
	localparam logic [3:0] CYC_XMEM = 4'h3;

	// instruction population per clock count
	localparam int INSTR_TOTAL = 109;
	localparam int INSTR_1CLK = 26;
	localparam int INSTR_2CLK = 50;
	localparam int INSTR_3CLK = 14;
	localparam int INSTR_4CLK = 3;
	localparam int INSTR_5CLK = 2;
	localparam int INSTR_8CLK = 1;

	// ------------------------------------------------------------
	// program store control bit positions and reset values
	// ------------------------------------------------------------
	localparam int PSC_WREN = 0; // steer external-data writes to flash
	localparam int PSC_ERASE = 1; // flash write acts as erase
	localparam logic [7:0] SFR_BASE = 8'h80; // top half of direct space
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ------------------------------------------------------------
	// instruction classes and sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		K_PLAIN = 3'b000,
		K_BRANCH = 3'b001,
		K_MUL = 3'b010,
		K_DIV = 3'b011,
		K_XRD = 3'b100,
		K_XWR = 3'b101,
		K_CODE = 3'b110,
		K_DPINC = 3'b111
	} ctm_kind_t;

	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_EXEC = 2'b01,
		ST_HALT = 2'b10
	} ctm_state_t;

endpackage

// ==== ctm_dec_if.sv ====
// Purpose: carries one opcode to the decoder and its timing back
// Assumes: purely combinational path inside one clock domain
// Notes: cyc is the taken-branch figure for conditional branches
`timescale 1ns/1ps
interface ctm_dec_if;
	import ctm_pkg::*;
	logic [7:0] opcode;
	logic [1:0] len;
	logic [3:0] cyc;
	ctm_kind_t kind;
	logic direct;
	logic indir;
	modport dec (input opcode, output len, cyc, kind, direct, indir);
	modport seq (output opcode, input len, cyc, kind, direct, indir);
endinterface

// ==== ctm_op_decode.sv ====
// Purpose: opcode to length, clock count and class lookup
// Assumes: opcode stable while it is being issued
// Notes: the low nibble picks the operand mode as in the standard set
`timescale 1ns/1ps
module ctm_op_decode (
	// decode channel
	ctm_dec_if.dec dbus
);
	import ctm_pkg::*;

	// ------------------------------------------------------------
	// lookup
	// ------------------------------------------------------------
	always_comb begin
		dbus.kind = K_PLAIN;
		dbus.direct = 1'b0;
		dbus.indir = 1'b0;
		case (dbus.opcode[3:0])
			4'h4: begin
				dbus.len = 2'd2;
			end
			4'h5: begin
				dbus.len = 2'd2;
				dbus.direct = 1'b1;
			end
			4'h6, 4'h7: begin
				dbus.len = 2'd1;
				dbus.indir = 1'b1;
			end
			4'h0, 4'h1, 4'h2, 4'h3: begin
				dbus.len = 2'd2;
			end
			default: begin
				dbus.len = 2'd1;
			end
		endcase
		dbus.cyc = {2'b00, dbus.len};
		if (dbus.indir) begin
			dbus.cyc = 4'h2;
		end
		case (dbus.opcode)
			8'h04, 8'h14, 8'hc4, 8'hd4, 8'he4, 8'hf4: begin
				dbus.len = 2'd1;
				dbus.cyc = CYC_ONE;
			end
			8'ha3: begin
				dbus.len = 2'd1;
				dbus.cyc = CYC_ONE;
				dbus.kind = K_DPINC;
			end
			8'ha4: begin
				dbus.len = 2'd1;
				dbus.cyc = CYC_MUL;
				dbus.kind = K_MUL;
			end
			8'h84: begin
				dbus.len = 2'd1;
				dbus.cyc = CYC_DIV;
				dbus.kind = K_DIV;
			end
			8'he0, 8'he2, 8'he3: begin
				dbus.len = 2'd1;
				dbus.cyc = CYC_XMEM;
				dbus.kind = K_XRD;
			end
			8'hf0, 8'hf2, 8'hf3: begin
				dbus.len = 2'd1;
				dbus.cyc = CYC_XMEM;
				dbus.kind = K_XWR;
			end
			8'h83, 8'h93: begin
				dbus.len = 2'd1;
				dbus.cyc = CYC_XMEM;
				dbus.kind = K_CODE;
			end
			8'h90: begin
				dbus.len = 2'd3;
				dbus.cyc = 4'h3;
			end
			8'h40, 8'h50, 8'h60, 8'h70,
			8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf: begin
				dbus.len = 2'd2;
				dbus.cyc = 4'h3;
				dbus.kind = K_BRANCH;
			end
			8'h10, 8'h20, 8'h30, 8'hd5,
			8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hba, 8'hbb,
			8'hbc, 8'hbd, 8'hbe, 8'hbf: begin
				dbus.len = 2'd3;
				dbus.cyc = 4'h4;
				dbus.kind = K_BRANCH;
				dbus.direct = 1'b0;
				dbus.indir = 1'b0;
			end
			default: begin
			end
		endcase
	end

endmodule // ctm_op_decode

// ==== ctm_core_timing_chk.sv ====
// Purpose: port-level timing checks on the instruction sequencer
// Assumes: program store control is held steady across a move
// Notes: bound into every instance of the sequencer
`timescale 1ns/1ps
module ctm_core_timing_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// issue side
	input wire logic op_valid,
	input wire logic [ctm_pkg::OPW-1:0] op_code,
	input wire logic [ctm_pkg::OPW-1:0] op_arg,
	input wire logic cond_true,
	input wire logic [1:0] program_store_control,
	// sequencer answers
	input wire logic op_ready,
	input wire logic instr_done,
	input wire logic [1:0] instr_len,
	input wire logic [ctm_pkg::CYW-1:0] instr_cycles,
	input wire logic flash_wr,
	input wire logic flash_erase,
	input wire logic flash_rd,
	input wire logic xram_wr,
	input wire logic sfr_sel,
	input wire logic ram_sel,
	input wire logic sixteen_bit_data_pointer_inc,
	input wire logic halted
);
	import ctm_pkg::*;
	// ------------------------------------------------------------
	// accepted opcode and clocking
	// ------------------------------------------------------------
	logic take;
	// an opcode is taken on an edge where it is offered and ready
	assign take = op_valid && op_ready;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ------------------------------------------------------------
	// timing properties
	// ------------------------------------------------------------
	property p_reg;
		take && op_code == 8'h28 |=> instr_len == 2'h1 && instr_cycles == CYC_ONE && instr_done;
	endproperty
	a_reg: assert property (p_reg) else $error("register add timing wrong");
	property p_dir;
		take && op_code == 8'h25 |=> instr_len == 2'h2 && instr_cycles == 4'h2 && !instr_done
			##1 instr_done;
	endproperty
	a_dir: assert property (p_dir) else $error("direct add timing wrong");
	property p_ind;
		take && op_code == 8'h26 |=> instr_len == 2'h1 && !instr_done ##1 instr_done;
	endproperty
	a_ind: assert property (p_ind) else $error("indirect add timing wrong");
	property p_mul;
		take && op_code == 8'hA4 |=> instr_cycles == CYC_MUL ##3 instr_done;
	endproperty
	a_mul: assert property (p_mul) else $error("multiply timing wrong");
	property p_div;
		take && op_code == 8'h84 |=> !instr_done [*7] ##1 instr_done;
	endproperty
	a_div: assert property (p_div) else $error("divide timing wrong");
	property p_bound;
		take |-> ##[1:8] instr_done;
	endproperty
	a_bound: assert property (p_bound) else $error("instruction too long");
	property p_skip;
		take && op_code == 8'h40 && !cond_true |=> instr_cycles == 4'h2 ##1 instr_done;
	endproperty
	a_skip: assert property (p_skip) else $error("branch shortcut wrong");
	property p_b2b;
		// a debug halt after the op is the only reason to drop ready
		take && op_code == 8'h28 |=> op_ready || halted;
	endproperty
	a_b2b: assert property (p_b2b) else $error("single clock op stalled");
	property p_fwr;
		take && op_code == 8'hF0 && program_store_control[0] |=> ##2 instr_done && flash_wr
			&& !xram_wr && flash_erase == program_store_control[1];
	endproperty
	a_fwr: assert property (p_fwr) else $error("flash write not steered");
	property p_xwr;
		take && op_code == 8'hF0 && !program_store_control[0] |=> ##2 xram_wr && !flash_wr;
	endproperty
	a_xwr: assert property (p_xwr) else $error("external write not steered");
	property p_crd;
		take && op_code == 8'h93 |=> ##2 instr_done && flash_rd;
	endproperty
	a_crd: assert property (p_crd) else $error("code read missing");
	property p_dpi;
		take && op_code == 8'hA3 |=> instr_done && sixteen_bit_data_pointer_inc;
	endproperty
	a_dpi: assert property (p_dpi) else $error("pointer increment wrong");
	property p_sfr;
		take && op_code == 8'h25 |=> sfr_sel == ($past(op_arg) >= SFR_BASE) && ram_sel != sfr_sel;
	endproperty
	a_sfr: assert property (p_sfr) else $error("direct space select wrong");
endmodule // ctm_core_timing_chk

bind ctm_core_timing ctm_core_timing_chk u_chk (.ref_clk, .srst, .op_valid, .op_code, .op_arg,
	.cond_true, .program_store_control, .op_ready, .instr_done, .instr_len, .instr_cycles,
	.flash_wr, .flash_erase, .flash_rd, .xram_wr, .sfr_sel, .ram_sel, .sixteen_bit_data_pointer_inc, .halted);

// ==== tb_top.sv ====
// Purpose: directed checks of the instruction sequencer
// Assumes: inputs change on the falling edge of ref_clk
// Notes: debug pins are held for several clocks to cross the synchroniser
`timescale 1ns/1ps
module tb_top;
	import ctm_pkg::*;
	// ------------------------------------------------------------
	// clock, ports and counters
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic op_valid = 1'b0, cond_true = 1'b0, bkpt_en = 1'b0, watch_en = 1'b0;
	logic dbg_halt_pin = 1'b0, dbg_run_pin = 1'b0, dbg_step_pin = 1'b0;
	logic [7:0] op_code = 8'h00, op_arg = 8'h00, acc_in = 8'h00, aux_in = 8'h00;
	logic [1:0] program_store_control = 2'h0;
	logic [15:0] pc_in = 16'h0000, bkpt_addr = 16'h0000, watch_addr = 16'h0000;
	logic [15:0] xdata_addr = 16'h0000;
	logic op_ready, instr_done, ov_flag, flash_wr, flash_erase, flash_rd, xram_rd, xram_wr;
	logic sfr_sel, ram_sel, sixteen_bit_data_pointer_inc, halted;
	logic [1:0] instr_len;
	logic [3:0] instr_cycles;
	logic [7:0] acc_out, aux_out;
	logic [5:0] pulses;
	int fail_count = 0, comparisons = 0, n = 0;

	// free running system clock
	always #12.5 ref_clk = ~ref_clk;

	ctm_core_timing uut (.ref_clk, .srst, .op_valid, .op_code, .op_arg, .cond_true, .op_ready,
		.instr_done, .instr_len, .instr_cycles, .acc_in, .aux_in, .acc_out, .aux_out, .ov_flag,
		.program_store_control, .flash_wr, .flash_erase, .flash_rd, .xram_rd, .xram_wr,
		.sfr_sel, .ram_sel, .sixteen_bit_data_pointer_inc, .dbg_halt_pin, .dbg_run_pin, .dbg_step_pin, .pc_in,
		.bkpt_en, .bkpt_addr, .watch_en, .watch_addr, .xdata_addr, .halted);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// offer one opcode, count clocks to its done pulse, capture the strobes
	task run_op(input logic [7:0] op, arg, input logic c, input logic [1:0] len,
		input logic [3:0] cyc);
		int i;
		for (i = 0; i < 40 && op_ready !== 1'b1; i++) @(negedge ref_clk);
		op_valid = 1'b1;
		op_code = op;
		op_arg = arg;
		cond_true = c;
		@(negedge ref_clk);
		op_valid = 1'b0;
		// done of an n-clock op is visible at the n-th falling edge after the offer
		for (n = 1; n < 12 && instr_done !== 1'b1; n++) @(negedge ref_clk);
		pulses = {flash_wr, flash_erase, flash_rd, xram_rd, xram_wr, sixteen_bit_data_pointer_inc};
		check(16'(n), 16'(cyc));
		check(16'(instr_len), 16'(len));
		check(16'(instr_cycles), 16'(cyc));
		if (instr_done !== 1'b1) tally_and_finish();
		// let one edge pass before the next offer
		@(negedge ref_clk);
	endtask

	// bounded wait for the halted level
	task wait_halt(input logic v);
		int i;
		for (i = 0; i < 40 && halted !== v; i++) @(negedge ref_clk);
		check(16'(halted), 16'(v));
		if (halted !== v) tally_and_finish();
	endtask

	// pulse a debug pin: 1 halt, 2 step, 4 run
	task pulse(input int w);
		{dbg_run_pin, dbg_step_pin, dbg_halt_pin} = 3'(w);
		repeat (6) @(negedge ref_clk);
		{dbg_run_pin, dbg_step_pin, dbg_halt_pin} = 3'h0;
		repeat (6) @(negedge ref_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_arith;
		logic [7:0] ops [12] = '{8'h28, 8'h38, 8'h98, 8'h25, 8'h35, 8'h95, 8'h26, 8'h36,
			8'h96, 8'h24, 8'h34, 8'h94};
		logic [1:0] lens [4] = '{2'h1, 2'h2, 2'h1, 2'h2};
		logic [3:0] cycs [4] = '{4'h1, 4'h2, 4'h2, 4'h2};
		int i;
		for (i = 0; i < 12; i++) run_op(ops[i], 8'h30, 1'b0, lens[i/3], cycs[i/3]);
	endtask

	task t_muldiv;
		acc_in = 8'h12;
		aux_in = 8'h34;
		run_op(8'hA4, 8'h00, 1'b0, 2'h1, 4'h4);
		check({aux_out, acc_out}, 16'h03A8);
		check(16'(ov_flag), 16'h0001);
		acc_in = 8'h64;
		aux_in = 8'h07;
		run_op(8'h84, 8'h00, 1'b0, 2'h1, 4'h8);
		check({aux_out, acc_out}, 16'h020E);
		check(16'(ov_flag), 16'h0000);
		run_op(8'hA3, 8'h00, 1'b0, 2'h1, 4'h1);
		check(16'(pulses), 16'h0001);
	endtask

	task t_branch;
		run_op(8'h40, 8'h05, 1'b1, 2'h2, 4'h3);
		run_op(8'h40, 8'h05, 1'b0, 2'h2, 4'h2);
		run_op(8'h20, 8'h05, 1'b1, 2'h3, 4'h4);
		run_op(8'h20, 8'h05, 1'b0, 2'h3, 4'h3);
	endtask

	task t_b2b;
		int k;
		n = 0;
		op_code = 8'h28;
		op_valid = 1'b1;
		for (k = 0; k < 6; k++) begin
			@(negedge ref_clk);
			if (k == 3) op_valid = 1'b0;
			if (instr_done === 1'b1) n++;
			if (k < 4) check(16'(op_ready), 16'h0001);
		end
		check(16'(n), 16'h0004);
	endtask

	task t_xmem;
		program_store_control = 2'h1;
		run_op(8'hF0, 8'h00, 1'b0, 2'h1, 4'h3);
		check(16'(pulses), 16'h0020);
		program_store_control = 2'h3;
		run_op(8'hF0, 8'h00, 1'b0, 2'h1, 4'h3);
		check(16'(pulses), 16'h0030);
		program_store_control = 2'h0;
		run_op(8'hF0, 8'h00, 1'b0, 2'h1, 4'h3);
		check(16'(pulses), 16'h0002);
		run_op(8'hE0, 8'h00, 1'b0, 2'h1, 4'h3);
		check(16'(pulses), 16'h0004);
		run_op(8'h93, 8'h00, 1'b0, 2'h1, 4'h3);
		check(16'(pulses), 16'h0008);
	endtask

	task t_sel;
		run_op(8'h25, 8'h80, 1'b0, 2'h2, 4'h2);
		check(16'({sfr_sel, ram_sel}), 16'h0002);
		run_op(8'h25, 8'h7F, 1'b0, 2'h2, 4'h2);
		check(16'({sfr_sel, ram_sel}), 16'h0001);
	endtask

	task t_debug;
		pulse(1);
		wait_halt(1'b1);
		@(negedge ref_clk);
		check(16'(op_ready), 16'h0000);
		pulse(2);
		run_op(8'h28, 8'h00, 1'b0, 2'h1, 4'h1);
		wait_halt(1'b1);
		pulse(4);
		wait_halt(1'b0);
		bkpt_en = 1'b1;
		bkpt_addr = 16'h0100;
		pc_in = 16'h0100;
		run_op(8'h28, 8'h00, 1'b0, 2'h1, 4'h1);
		wait_halt(1'b1);
		bkpt_en = 1'b0;
		watch_en = 1'b1;
		watch_addr = 16'h0200;
		xdata_addr = 16'h0200;
		pulse(4);
		run_op(8'hE0, 8'h00, 1'b0, 2'h1, 4'h3);
		wait_halt(1'b1);
		watch_en = 1'b0;
		pulse(4);
		wait_halt(1'b0);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		srst = 1'b0;
		t_arith();
		t_muldiv();
		t_branch();
		t_b2b();
		t_xmem();
		t_sel();
		t_debug();
		tally_and_finish();
	end
endmodule // tb_top
